// ===== pud_ctrl.sv
// Profile select, register transfer, internal update and power-down control.
// Assumes profile, update and power-down pins are asynchronous, and that a
// serial front end on core_clk delivers whole words to the buffer port.
`timescale 1ns/100ps
`default_nettype none

module pud_ctrl
  import pud_pkg::*;
#(
  parameter int unsigned DATA_W = 64
)(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     clkEn,
  // Buffer write port from the serial front end
  input  wire logic                     bufWrEn,
  input  wire logic [pud_pkg::ADDR_W-1:0] bufAddr,
  input  wire logic [DATA_W-1:0]        bufWrData,
  // Device pins
  input  wire logic [2:0]               profilePins,
  input  wire logic                     updPinIn,
  output logic                          updPinOut,
  output logic                          updPinOe,
  input  wire logic                     external_powerdown_pin,
  output logic                          syncClkOut,
  // Active state towards the synthesizer core
  output logic [2:0]                    profileIndex,
  output logic [DATA_W-1:0]             activeProfileWord,
  output logic                          ramProfileFmt,
  output logic                          xferPulse,
  // Power-down controls
  output logic                          pdCore,
  output logic                          pdDac,
  output logic                          pdAux,
  output logic                          pdRefClk,
  output logic                          fastRecoveryHold
);
  import pud_pkg::*;

  initial begin
    if (DATA_W < 32 || DATA_W > 64) $error("DATA_W must lie between 32 and 64");
  end

  // Buffered and active registers
  logic [31:0]       cfr1Buf_q, cfr1Act_q;
  logic [31:0]       cfr2Buf_q, cfr2Act_q;
  logic [31:0]       intervalBuf_q, intervalAct_q;
  logic [DATA_W-1:0] profBuf_q [PROFILES];
  logic [DATA_W-1:0] profAct_q [PROFILES];

  // Synchronisers and timing
  logic [2:0] profS1_q, profS2_q;
  logic       updS1_q, updS2_q, updS3_q;
  logic       pdS1_q, pdS2_q;
  logic [1:0] divCnt_q;
  logic [2:0] profSel_q;
  logic       updPending_q;

  // Output registers
  logic              syncClk_q;
  logic              updOut_q, updOe_q;
  logic [DATA_W-1:0] activeWord_q;
  logic              ramFmt_q, xfer_q;
  logic              pdCore_q, pdDac_q, pdAux_q, pdRefClk_q, fastHold_q;

  // Timer results
  logic timerFire;
  logic timerPin;

  // Decode and selection
  logic        syncEdge;
  logic        intActive;
  logic        extRise;
  logic        profChange;
  logic        xferGo;
  logic        coreDown;
  logic        recoverWr;
  logic        wrAccept;
  logic        hitCfr1, hitCfr2, hitInterval;
  logic        fastMode;
  logic [31:0] wrWord;

  assign syncEdge    = divCnt_q == SYNC_RISE_PHASE;
  assign intActive   = cfr2Act_q[CONTROL_FUNCTION_REG2_INT_UPD];
  assign extRise     = updS2_q && !updS3_q && !intActive;
  assign profChange  = syncEdge && (profS2_q != profSel_q);
  assign xferGo      = (syncEdge && updPending_q) || profChange;
  assign coreDown    = pdS2_q || cfr1Act_q[CONTROL_FUNCTION_REG1_PD_CORE];
  assign wrWord      = bufWrData[31:0];
  assign hitCfr1     = bufAddr == REG_CONTROL_FUNCTION_REG1;
  assign hitCfr2     = bufAddr == REG_CONTROL_FUNCTION_REG2;
  assign hitInterval = bufAddr == REG_INTERVAL;
  assign recoverWr   = bufWrEn && coreDown && hitCfr1 && !wrWord[CONTROL_FUNCTION_REG1_PD_CORE];
  assign wrAccept    = bufWrEn && (!coreDown || recoverWr);
  assign fastMode    = cfr1Act_q[CONTROL_FUNCTION_REG1_EXT_PD_FST];

  // Quarter-rate sync clock; rises as the count leaves the chosen phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q  <= 2'h0;
      syncClk_q <= 1'b0;
    end else if (clkEn) begin
      divCnt_q  <= divCnt_q + 2'h1;
      syncClk_q <= (divCnt_q == SYNC_RISE_PHASE) || (divCnt_q == SYNC_RISE_PHASE + 2'h1);
    end
  end

  // Two stages for every pin input before any logic reads it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      profS1_q <= 3'h0;
      profS2_q <= 3'h0;
      updS1_q  <= 1'b0;
      updS2_q  <= 1'b0;
      updS3_q  <= 1'b0;
      pdS1_q   <= 1'b0;
      pdS2_q   <= 1'b0;
    end else if (clkEn) begin
      profS1_q <= profilePins;
      profS2_q <= profS1_q;
      updS1_q  <= updPinIn;
      updS2_q  <= updS1_q;
      updS3_q  <= updS2_q;
      pdS1_q   <= external_powerdown_pin;
      pdS2_q   <= pdS1_q;
    end
  end

  // Profile index is taken only on sync clock rising edges
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      profSel_q <= 3'h0;
    end else if (clkEn && syncEdge) begin
      profSel_q <= profS2_q;
    end
  end

  // Pending update: an edge landing on the service cycle is kept, not lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      updPending_q <= 1'b0;
    end else if (clkEn) begin
      if (extRise || timerFire) updPending_q <= 1'b1;
      else if (syncEdge) updPending_q <= 1'b0;
    end
  end

  // Control buffers; only a recovery write clearing the core bit acts before transfer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfr1Buf_q     <= CONTROL_FUNCTION_REG1_RESET;
      cfr2Buf_q     <= CONTROL_FUNCTION_REG2_RESET;
      intervalBuf_q <= INTERVAL_RESET;
    end else if (clkEn && wrAccept) begin
      if (hitCfr1) cfr1Buf_q <= wrWord;
      if (hitCfr2) cfr2Buf_q <= wrWord;
      if (hitInterval) intervalBuf_q <= wrWord;
    end
  end

  // Active controls; the core bit may clear at once so the part can recover
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfr1Act_q     <= CONTROL_FUNCTION_REG1_RESET;
      cfr2Act_q     <= CONTROL_FUNCTION_REG2_RESET;
      intervalAct_q <= INTERVAL_RESET;
    end else if (clkEn) begin
      if (xferGo) begin
        cfr1Act_q     <= cfr1Buf_q;
        cfr2Act_q     <= cfr2Buf_q;
        intervalAct_q <= intervalBuf_q;
      end else if (recoverWr) begin
        cfr1Act_q[CONTROL_FUNCTION_REG1_PD_CORE] <= 1'b0;
      end
    end
  end

  // One buffered and one active word per profile
  for (genvar p = 0; p < PROFILES; p++) begin : gProf
    logic profHit;
    assign profHit = wrAccept && (bufAddr == ADDR_W'(REG_PROFILE_SELECT_BIT0 + p));
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        profBuf_q[p] <= '0;
        profAct_q[p] <= '0;
      end else if (clkEn) begin
        if (profHit) profBuf_q[p] <= bufWrData;
        if (xferGo) profAct_q[p] <= profBuf_q[p];
      end
    end
  end

  // Internal update generator
  pud_update_timer u_timer (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .enable    (intActive),
    .rateSel   (cfr2Act_q[CONTROL_FUNCTION_REG2_RATE_HI:CONTROL_FUNCTION_REG2_RATE_LO]),
    .interval  (intervalAct_q),
    .fire_q    (timerFire),
    .pinHigh_q (timerPin)
  );

  // Update pin turns round only with the active control word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      updOe_q  <= 1'b0;
      updOut_q <= 1'b0;
    end else if (clkEn) begin
      updOe_q  <= intActive;
      updOut_q <= intActive && timerPin;
    end
  end

  // Active profile word follows the latched index, one cycle behind
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeWord_q <= '0;
      ramFmt_q     <= 1'b0;
      xfer_q       <= 1'b0;
    end else if (clkEn) begin
      activeWord_q <= profAct_q[profSel_q];
      ramFmt_q     <= cfr1Act_q[CONTROL_FUNCTION_REG1_RAM_EN];
      xfer_q       <= xferGo;
    end
  end

  // Pin overrides the bits; fast recovery keeps the clock input alive
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pdCore_q   <= 1'b0;
      pdDac_q    <= 1'b0;
      pdAux_q    <= 1'b0;
      pdRefClk_q <= 1'b0;
      fastHold_q <= 1'b0;
    end else if (clkEn) begin
      pdCore_q   <= pdS2_q || cfr1Act_q[CONTROL_FUNCTION_REG1_PD_CORE];
      pdDac_q    <= pdS2_q || cfr1Act_q[CONTROL_FUNCTION_REG1_PD_DAC];
      pdAux_q    <= pdS2_q || cfr1Act_q[CONTROL_FUNCTION_REG1_PD_AUX];
      pdRefClk_q <= pdS2_q ? !fastMode : cfr1Act_q[CONTROL_FUNCTION_REG1_PD_REFCLK];
      fastHold_q <= pdS2_q && fastMode;
    end
  end

  assign syncClkOut        = syncClk_q;
  assign updPinOut         = updOut_q;
  assign updPinOe          = updOe_q;
  assign profileIndex      = profSel_q;
  assign activeProfileWord = activeWord_q;
  assign ramProfileFmt     = ramFmt_q;
  assign xferPulse         = xfer_q;
  assign pdCore            = pdCore_q;
  assign pdDac             = pdDac_q;
  assign pdAux             = pdAux_q;
  assign pdRefClk          = pdRefClk_q;
  assign fastRecoveryHold  = fastHold_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence sEdgeTaken;
    clkEn && syncEdge && updPending_q;
  endsequence
  sequence sXferSeen;
    xfer_q && (cfr2Act_q == $past(cfr2Buf_q));
  endsequence
  sequence sPinEdge;
    clkEn && extRise;
  endsequence

  sync_div_a : assert property (clkEn [*5] |-> syncClk_q == $past(syncClk_q, 4))
    else $error("sync clock period not four system clocks");
  prof_sel_a : assert property (clkEn && syncEdge |=> profSel_q == $past(profS2_q))
    else $error("profile index not taken on sync edge");
  prof_xfer_a : assert property (clkEn && syncEdge && profS2_q != profSel_q |-> xferGo)
    else $error("profile change did not transfer");
  buf_hold_a : assert property (clkEn && !xferGo |=> $stable(cfr2Act_q))
    else $error("active register changed without transfer");
  ext_upd_a : assert property (clkEn && extRise |=> updPending_q)
    else $error("update pin edge lost");
  upd_walk_a : assert property (sEdgeTaken ##1 clkEn |-> sXferSeen)
    else $error("pending update not transferred at sync edge");
  oe_int_a : assert property (clkEn |=> updOe_q == $past(cfr2Act_q[CONTROL_FUNCTION_REG2_INT_UPD]))
    else $error("update pin direction wrong");
  pd_ext_a : assert property (clkEn && pdS2_q |=> pdCore_q && pdDac_q && pdAux_q)
    else $error("power-down pin did not override bits");
  pd_soft_a : assert property (clkEn && !pdS2_q |=> pdDac_q == $past(cfr1Act_q[CONTROL_FUNCTION_REG1_PD_DAC]))
    else $error("software DAC power-down not followed");
  pd_block_a : assert property (clkEn && coreDown && bufWrEn && hitCfr2 |=> $stable(cfr2Buf_q))
    else $error("write accepted during core power-down");
  ram_fmt_a : assert property (clkEn |=> ramFmt_q == $past(cfr1Act_q[CONTROL_FUNCTION_REG1_RAM_EN]))
    else $error("profile format select wrong");

  // Reset values feed the first internal update period
  rst_val_a : assert property ($rose(reset_n) |->
    intervalAct_q == INTERVAL_RESET && cfr2Act_q[CONTROL_FUNCTION_REG2_RATE_HI:CONTROL_FUNCTION_REG2_RATE_LO] == 2'h0)
    else $error("rate settings wrong after reset");
  sync_rise_a : assert property (clkEn && syncEdge |=> syncClk_q && !$past(syncClk_q))
    else $error("sync clock did not rise after sync edge");
  ext_walk_a : assert property (sPinEdge |-> ##[1:4] (clkEn && xferGo))
    else $error("update pin edge not transferred within a sync period");
  pend_set_a : assert property (clkEn && timerFire |=> updPending_q)
    else $error("internal update not queued");
  prof_copy_a : assert property (clkEn && xferGo |=> profAct_q[0] == $past(profBuf_q[0]))
    else $error("profile buffer not copied on transfer");
  word_sel_a : assert property (clkEn |=> activeWord_q == $past(profAct_q[profSel_q]))
    else $error("active word not from selected profile");
  upd_static_a : assert property ((clkEn && intActive && intervalAct_q <= STATIC_LIMIT) [*2] |=> updOut_q)
    else $error("update pin not static high");
  pd_full_a : assert property (clkEn && pdS2_q && !fastMode |=> pdRefClk_q && !fastHold_q)
    else $error("full power-down left clock input on");
  pd_fast_a : assert property (clkEn && pdS2_q && fastMode |=> fastHold_q && !pdRefClk_q)
    else $error("fast recovery power-down wrong");
  fast_soft_a : assert property (clkEn && !pdS2_q |=> !fastHold_q)
    else $error("fast recovery hold without power-down pin");
  pd_wake_a : assert property (clkEn && recoverWr && !xferGo |=> !cfr1Act_q[CONTROL_FUNCTION_REG1_PD_CORE])
    else $error("core power-down bit not cleared by recovery write");

endmodule // pud_ctrl
`default_nettype wire

// ===== pud_ext_ctrl.sv
// External controller model driving the profile, update and power-down pins.
// Assumes the bench sets request levels; they reach the pins on sync clock rises.
`timescale 1ns/100ps
`default_nettype none
module pud_ext_ctrl (
  // Device outputs
  input  wire logic       syncClkOut,
  input  wire logic       updPinOe,
  // Requests from the bench
  input  wire logic [2:0] reqProfile,
  input  wire logic       reqUpd,
  input  wire logic       reqPd,
  // Pins
  output logic [2:0]      profilePins,
  output logic            updDrive,
  output logic            updDriveEn,
  output logic            pdPin
);
  initial begin
    profilePins = 3'h0;
    updDrive = 1'b0;
    pdPin = 1'b0;
  end
  // Moving only on sync rises keeps profile setup and hold clean
  always @(posedge syncClkOut) begin
    profilePins <= reqProfile;
    updDrive    <= reqUpd;
    pdPin       <= reqPd;
  end
  // Let go of the pin while the device drives it, avoiding contention
  assign updDriveEn = !updPinOe;
endmodule // pud_ext_ctrl
`default_nettype wire

// ===== pud_pkg.sv
// Constants shared by the profile, update and power-down control block.
// Assumes a 50 MHz system clock on core_clk and a serial front end that
// delivers whole register words to the buffer write port.
package pud_pkg;

  // Register buffer indices (word addresses on the buffer write port)
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  REG_CONTROL_FUNCTION_REG1        = 5'h00;
  localparam logic [4:0]  REG_CONTROL_FUNCTION_REG2        = 5'h01;
  localparam logic [4:0]  REG_INTERVAL    = 5'h04;
  localparam logic [4:0]  REG_PROFILE_SELECT_BIT0    = 5'h0E;

  // Control function register 1 fields
  localparam int unsigned CONTROL_FUNCTION_REG1_RAM_EN     = 31;
  localparam int unsigned CONTROL_FUNCTION_REG1_PD_CORE    = 7;
  localparam int unsigned CONTROL_FUNCTION_REG1_PD_DAC     = 6;
  localparam int unsigned CONTROL_FUNCTION_REG1_PD_AUX     = 5;
  localparam int unsigned CONTROL_FUNCTION_REG1_PD_REFCLK  = 4;
  localparam int unsigned CONTROL_FUNCTION_REG1_EXT_PD_FST = 3;

  // Control function register 2 fields
  localparam int unsigned CONTROL_FUNCTION_REG2_INT_UPD    = 23;
  localparam int unsigned CONTROL_FUNCTION_REG2_RATE_HI    = 15;
  localparam int unsigned CONTROL_FUNCTION_REG2_RATE_LO    = 14;

  // Values after reset
  localparam logic [31:0] CONTROL_FUNCTION_REG1_RESET      = 32'h0000_0000;
  localparam logic [31:0] CONTROL_FUNCTION_REG2_RESET      = 32'h0000_0000;
  localparam logic [31:0] INTERVAL_RESET  = 32'h0000_FFFF;

  // Timing counts in system clock cycles; STATIC_LIMIT is in interval steps
  localparam int unsigned SYNC_DIV        = 4;
  localparam logic [1:0]  SYNC_RISE_PHASE = 2'h1;
  localparam logic [6:0]  UPD_PULSE_BASE  = 7'h0C;
  localparam logic [31:0] STATIC_LIMIT    = 32'h0000_0003;

  // Number of profile register sets
  localparam int unsigned PROFILES        = 8;

endpackage

// ===== pud_update_timer.sv
// Internal update generator: repetition timer and output pulse shaper.
// Assumes the caller holds enable low while external updates are in use.
`timescale 1ns/100ps
`default_nettype none
module pud_update_timer
  import pud_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // Settings
  input  wire logic        enable,
  input  wire logic [1:0]  rateSel,
  input  wire logic [31:0] interval,
  // Results
  output logic             fire_q,
  output logic             pinHigh_q
);
  logic [4:0]  preCnt_q;
  logic [31:0] tickCnt_q;
  logic [6:0]  widthCnt_q;
  logic [4:0]  preLast;
  logic        preTick;
  logic        cntLast;
  logic        staticHigh;
  logic [6:0]  widthLoad;

  // Quarter-rate clock further divided by 1, 2, 4 or 8
  assign preLast    = 5'((SYNC_DIV << rateSel) - 1);
  assign preTick    = enable && (preCnt_q == preLast);
  assign cntLast    = (interval != 32'h0000_0000) && (tickCnt_q >= interval - 32'h0000_0001);
  assign staticHigh = interval <= STATIC_LIMIT;
  assign widthLoad  = UPD_PULSE_BASE << rateSel;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_q   <= 5'h00;
      tickCnt_q  <= 32'h0000_0000;
      widthCnt_q <= 7'h00;
      fire_q     <= 1'b0;
      pinHigh_q  <= 1'b0;
    end else if (clkEn) begin
      preCnt_q   <= (!enable || preTick) ? 5'h00 : preCnt_q + 5'h01;
      fire_q     <= preTick && cntLast;
      if (!enable) tickCnt_q <= 32'h0000_0000;
      else if (preTick) tickCnt_q <= cntLast ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
      if (!enable) widthCnt_q <= 7'h00;
      else if (preTick && cntLast) widthCnt_q <= widthLoad;
      else if (widthCnt_q != 7'h00) widthCnt_q <= widthCnt_q - 7'h01;
      pinHigh_q  <= enable && (staticHigh || (preTick && cntLast) || widthCnt_q > 7'h01);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  static_a : assert property (clkEn && enable && staticHigh |=> pinHigh_q)
    else $error("update pin not held high at small interval");
  width_a : assert property (clkEn && fire_q && !staticHigh && rateSel == 2'h0 |-> pinHigh_q)
    else $error("update pulse missing at internal update");
  tick_a : assert property (clkEn && preTick && cntLast |=> fire_q)
    else $error("internal update not fired at count end");

endmodule // pud_update_timer
`default_nettype wire

// ===== tb_profile_update_powerdown_ctrl.sv
// Self-checking bench for the profile, update and power-down control block.
// Assumes the external controller model sits on the pin side.
`timescale 1ns/100ps
`default_nettype none
module tb_profile_update_powerdown_ctrl;
  import pud_pkg::*;
  logic        core_clk;
  logic        reset_n;
  logic        bufWrEn;
  logic [4:0]  bufAddr;
  logic [63:0] bufWrData;
  logic [2:0]  reqProfile;
  logic        reqUpd;
  logic        reqPd;
  logic [2:0]  profilePins;
  logic        updDrive;
  logic        updDriveEn;
  logic        pdPin;
  logic        updPinOut;
  logic        updPinOe;
  logic        syncClkOut;
  logic [2:0]  profileIndex;
  logic [63:0] activeProfileWord;
  logic        ramProfileFmt;
  logic        xferPulse;
  logic        pdCore;
  logic        pdDac;
  logic        pdAux;
  logic        pdRefClk;
  logic        fastRecoveryHold;
  logic        updWire;
  int          err_count;
  int          n_tests;
  int          cycles;

  // Update pin level from whichever side drives it
  assign updWire = updDriveEn ? updDrive : updPinOut;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  pud_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .clkEn(1'b1), .bufWrEn(bufWrEn), .bufAddr(bufAddr),
    .bufWrData(bufWrData), .profilePins(profilePins), .updPinIn(updWire), .updPinOut(updPinOut),
    .updPinOe(updPinOe), .external_powerdown_pin(pdPin), .syncClkOut(syncClkOut), .profileIndex(profileIndex),
    .activeProfileWord(activeProfileWord), .ramProfileFmt(ramProfileFmt), .xferPulse(xferPulse),
    .pdCore(pdCore), .pdDac(pdDac), .pdAux(pdAux), .pdRefClk(pdRefClk), .fastRecoveryHold(fastRecoveryHold));

  pud_ext_ctrl partner (.syncClkOut(syncClkOut), .updPinOe(updPinOe), .reqProfile(reqProfile), .reqUpd(reqUpd),
    .reqPd(reqPd), .profilePins(profilePins), .updDrive(updDrive), .updDriveEn(updDriveEn), .pdPin(pdPin));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs about 4000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [4:0] addr, input logic [63:0] data);
    @(negedge core_clk);
    bufWrEn = 1'b1;
    bufAddr = addr;
    bufWrData = data;
    @(negedge core_clk);
    bufWrEn = 1'b0;
  endtask

  task automatic waitXfer();
    int i;
    for (i = 0; i < 40 && xferPulse !== 1'b1; i++) @(negedge core_clk);
    chk("xferPulse", 64'h1, 64'(xferPulse));
    idle(3);
  endtask

  task automatic extUpd();
    @(negedge core_clk);
    reqUpd = 1'b1;
    waitXfer();
    reqUpd = 1'b0;
    idle(10);
  endtask

  function automatic logic [63:0] pat(input int p);
    return 64'h0123_4567_89AB_CD00 + 64'(p);
  endfunction

  task automatic t_reset();
    chk("reset outs", 64'h0, 64'({pdCore, pdDac, pdAux, pdRefClk, updPinOe, profileIndex}));
  endtask

  task automatic t_buffer();
    wr(REG_PROFILE_SELECT_BIT0, pat(0));
    idle(12);
    chk("held word", 64'h0, activeProfileWord);
    extUpd();
    chk("updated word", pat(0), activeProfileWord);
  endtask

  task automatic t_profiles();
    int p;
    for (int i = 1; i <= 8; i++) begin
      p = i % 8;
      wr(5'(REG_PROFILE_SELECT_BIT0 + p), pat(p));
      reqProfile = 3'(p);
      waitXfer();
      chk("profileIndex", 64'(p), 64'(profileIndex));
      chk("profile word", pat(p), activeProfileWord);
    end
  endtask

  task automatic t_sync();
    int n;
    logic prev;
    n = 0;
    prev = syncClkOut;
    repeat (40) begin
      @(negedge core_clk);
      if (syncClkOut === 1'b1 && prev === 1'b0) n++;
      prev = syncClkOut;
    end
    chk("sync rises", 64'(40 / SYNC_DIV), 64'(n));
  endtask

  task automatic t_pd();
    wr(REG_CONTROL_FUNCTION_REG1, 64'h8000_0078);
    extUpd();
    chk("ram pd bits", 64'h17, 64'({ramProfileFmt, pdCore, pdDac, pdAux, pdRefClk}));
    reqPd = 1'b1;
    idle(12);
    chk("pin pd", 64'h1D, 64'({pdCore, pdDac, pdAux, pdRefClk, fastRecoveryHold}));
    reqPd = 1'b0;
    idle(12);
    chk("soft pd", 64'h7, 64'({pdCore, pdDac, pdAux, pdRefClk}));
    wr(REG_CONTROL_FUNCTION_REG1, 64'h80);
    extUpd();
    chk("core pd", 64'h1, 64'(pdCore));
    wr(REG_PROFILE_SELECT_BIT0, 64'hDEAD);
    extUpd();
    chk("blocked word", pat(0), activeProfileWord);
    wr(REG_CONTROL_FUNCTION_REG1, 64'h0);
    idle(2);
    chk("core wake", 64'h0, 64'(pdCore));
    reqPd = 1'b1;
    idle(12);
    chk("full pin pd", 64'h1E, 64'({pdCore, pdDac, pdAux, pdRefClk, fastRecoveryHold}));
    reqPd = 1'b0;
    idle(12);
    chk("pd released", 64'h0, 64'({pdCore, pdDac, pdAux, pdRefClk}));
  endtask

  task automatic meas(output int w, output int per);
    int i;
    for (i = 0; i < 600 && updPinOut !== 1'b0; i++) @(negedge core_clk);
    for (i = 0; i < 600 && updPinOut !== 1'b1; i++) @(negedge core_clk);
    w = 0;
    while (updPinOut === 1'b1 && w < 600) begin
      w++;
      @(negedge core_clk);
    end
    per = w;
    while (updPinOut === 1'b0 && per < 2000) begin
      per++;
      @(negedge core_clk);
    end
  endtask

  task automatic t_auto();
    int w;
    int per;
    int h;
    wr(REG_INTERVAL, 64'h8);
    wr(REG_CONTROL_FUNCTION_REG2, 64'h0080_0000);
    extUpd();
    chk("updPinOe", 64'h1, 64'(updPinOe));
    for (int a = 0; a < 4; a++) begin
      wr(REG_CONTROL_FUNCTION_REG2, 64'h0080_0000 | (64'(a) << 14));
      idle(600);
      meas(w, per);
      chk("period", 64'(32 << a), 64'(per));
      chk("pulse width", 64'h1, 64'(w >= (12 << a) - 1 && w <= (12 << a) + 1));
    end
    wr(REG_INTERVAL, 64'h3);
    idle(600);
    h = 0;
    repeat (40) begin
      @(negedge core_clk);
      if (updPinOut === 1'b1) h++;
    end
    chk("static high", 64'd40, 64'(h));
  endtask

  initial begin
    err_count = 0;
    n_tests = 0;
    cycles = 0;
    reset_n = 1'b0;
    bufWrEn = 1'b0;
    bufAddr = 5'h00;
    bufWrData = 64'h0;
    reqProfile = 3'h0;
    reqUpd = 1'b0;
    reqPd = 1'b0;
    idle(16);
    reset_n = 1'b1;
    idle(4);
    t_reset();
    t_buffer();
    t_profiles();
    t_sync();
    t_pd();
    t_auto();
    end_of_test();
  end
endmodule // tb_profile_update_powerdown_ctrl
`default_nettype wire
